/* sls_pkg.sv */
// Constants, register map and carrier types of the learning and storm policing stage
// Assumes one 25 MHz clock and a synchronous plain register port
package sls_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NPORT = 5;
  localparam int NPOL = 4;
  localparam logic [2:0] CPU_PORT = 3'h4;
  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] A_PORT_CFG = 8'h00;
  localparam logic [7:0] A_GLOBAL = 8'h20;
  localparam logic [7:0] A_STORM_CFG = 8'h30;
  localparam logic [7:0] A_STORM_BURST = 8'h40;
  localparam logic [7:0] A_TOKENS = 8'h50;
  localparam logic [7:0] A_LEARN_CNT = 8'h54;
  localparam logic [7:0] A_DROP_CNT = 8'h58;
  // Port config fields
  localparam int F_ON = 0;
  localparam int F_AUTO = 1;
  localparam int F_COPY = 2;
  localparam int F_DISC = 3;
  localparam int F_LIM_COPY = 4;
  localparam int F_LIM_DISC = 5;
  localparam int F_LCK_COPY = 6;
  localparam int F_LCK_DISC = 7;
  localparam logic [7:0] PORT_CFG_RST = 8'h03;
  // Global fields
  localparam int F_IGNORE = 0;
  localparam int F_LRN_Q = 4;
  localparam int F_LCK_Q = 8;
  localparam int F_ADR_Q = 12;
  localparam logic [15:0] GLOBAL_RST = 16'h0000;
  // Storm config fields
  localparam int F_RATE = 0;
  localparam int F_UNIT = 4;
  localparam int F_MODE = 5;
  localparam int F_EN = 7;
  localparam logic [7:0] STORM_CFG_RST = 8'h00;
  localparam logic [31:0] STORM_BURST_RST = 32'h10101010;
  localparam logic [3:0] MAX_RATE_EXP = 4'ha;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [22:0] TICKS_PER_S = 23'd1000000;
  localparam logic [22:0] KILO = 23'd1000;
  // ----------------------------------------
  // Enumerations and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    SM_CLR_CPU_QUEUE_SET = 2'b00,
    SM_CLR_DESTINATION_PORT_SET = 2'b01,
    SM_CLR_BOTH = 2'b10,
    SM_CLR_ALL = 2'b11
  } sls_storm_mode_t;
  typedef struct packed {
    logic valid;
    logic [2:0] physical_ingress_port;
    logic [2:0] logical_ingress_port;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [11:0] vid;
    logic [NPORT-1:0] destination_port_set;
    logic [7:0] cpu_queue_set;
    logic learning_disable_flag;
    logic ingress_policed;
    logic flooded;
    logic port_group_mask_cpu;
  } sls_frame_t;
  typedef struct packed {
    logic hit;
    logic locked;
    logic [2:0] entry_destination_index;
    logic source_kill_flag;
    logic entry_cpu_copy_flag;
    logic limit_exceeded;
  } sls_lookup_t;
  typedef struct packed {
    logic valid;
    logic [47:0] smac;
    logic [11:0] vid;
    logic [2:0] port;
  } sls_learn_t;
  typedef struct packed {
    logic valid;
    logic [NPORT-1:0] destination_port_set;
    logic [7:0] cpu_queue_set;
    logic learn_frame;
    logic storm_dropped;
  } sls_result_t;
endpackage : sls_pkg

/* sls_smac_storm.sv */
// Source address learning decision and four switch-wide storm policers
// Assumes frame and lookup result arrive together, synchronous to ref_clk
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sls_smac_storm
  import sls_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Frame from earlier analyzer steps
  input wire sls_frame_t frame_i,
  input wire sls_lookup_t lookup_i,
  // Results
  output sls_result_t result_o,
  output sls_learn_t learn_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] port_cfg_q [NPORT];
  logic [15:0] global_q;
  logic [7:0] storm_cfg_q [NPOL];
  logic [31:0] storm_burst_q;
  logic [7:0] tokens_q [NPOL];
  logic [15:0] learn_cnt_q;
  logic [15:0] drop_cnt_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NPORT; i++) begin
        port_cfg_q[i] <= PORT_CFG_RST;
      end
      for (int i = 0; i < NPOL; i++) begin
        storm_cfg_q[i] <= STORM_CFG_RST;
      end
      global_q <= GLOBAL_RST;
      storm_burst_q <= STORM_BURST_RST;
    end else if (reg_wr) begin
      for (int i = 0; i < NPORT; i++) begin
        if (reg_addr == A_PORT_CFG + 8'(4 * i)) begin
          port_cfg_q[i] <= reg_wdata[7:0];
        end
      end
      for (int i = 0; i < NPOL; i++) begin
        if (reg_addr == A_STORM_CFG + 8'(4 * i)) begin
          storm_cfg_q[i] <= reg_wdata[7:0];
        end
      end
      if (reg_addr == A_GLOBAL) begin
        global_q <= reg_wdata[15:0];
      end
      if (reg_addr == A_STORM_BURST) begin
        storm_burst_q <= reg_wdata;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    for (int i = 0; i < NPORT; i++) begin
      if (reg_addr == A_PORT_CFG + 8'(4 * i)) begin
        rdata_d = {24'h0, port_cfg_q[i]};
      end
    end
    for (int i = 0; i < NPOL; i++) begin
      if (reg_addr == A_STORM_CFG + 8'(4 * i)) begin
        rdata_d = {24'h0, storm_cfg_q[i]};
      end
    end
    case (reg_addr)
      A_GLOBAL: rdata_d = {16'h0, global_q};
      A_STORM_BURST: rdata_d = storm_burst_q;
      A_TOKENS: rdata_d = {tokens_q[3], tokens_q[2], tokens_q[1], tokens_q[0]};
      A_LEARN_CNT: rdata_d = {16'h0, learn_cnt_q};
      A_DROP_CNT: rdata_d = {16'h0, drop_cnt_q};
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 32'h0;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------
  // Learn classification
  // ----------------------------------------
  logic [7:0] pcfg;
  logic learn_ok;
  logic move_cond;
  logic normal_lrn;
  logic limit_lrn;
  logic locked_lrn;
  logic use_flags;
  logic to_cpu_lrn;
  logic [NPORT-1:0] dest1;
  logic [7:0] cpuq1;

  always_comb begin
    pcfg = 8'h0;
    for (int i = 0; i < NPORT; i++) begin
      if (frame_i.physical_ingress_port == 3'(i)) begin
        pcfg = port_cfg_q[i];
      end
    end
  end

  always_comb begin
    learn_ok = frame_i.valid && pcfg[F_ON]
      && !frame_i.learning_disable_flag
      && !frame_i.ingress_policed;
    move_cond = !lookup_i.hit || (!lookup_i.locked
      && lookup_i.entry_destination_index != frame_i.logical_ingress_port);
    normal_lrn = learn_ok && move_cond && !lookup_i.limit_exceeded;
    limit_lrn = learn_ok && move_cond && lookup_i.limit_exceeded;
    locked_lrn = learn_ok && lookup_i.hit && lookup_i.locked
      && lookup_i.entry_destination_index != frame_i.logical_ingress_port;
    use_flags = frame_i.valid && lookup_i.hit && !global_q[F_IGNORE];
    dest1 = frame_i.destination_port_set;
    cpuq1 = frame_i.cpu_queue_set;
    to_cpu_lrn = 1'b0;
    if (normal_lrn && pcfg[F_DISC]) begin
      dest1 = '0;
    end
    if (limit_lrn && pcfg[F_LIM_DISC]) begin
      dest1 = '0;
    end
    if (locked_lrn && pcfg[F_LCK_DISC]) begin
      dest1 = '0;
    end
    if ((normal_lrn && pcfg[F_COPY]) || (limit_lrn && pcfg[F_LIM_COPY])) begin
      dest1[CPU_PORT] = 1'b1;
      cpuq1[global_q[F_LRN_Q +: 3]] = 1'b1;
      to_cpu_lrn = 1'b1;
    end
    if (locked_lrn && pcfg[F_LCK_COPY]) begin
      dest1[CPU_PORT] = 1'b1;
      cpuq1[global_q[F_LCK_Q +: 3]] = 1'b1;
      to_cpu_lrn = 1'b1;
    end
    if (use_flags && lookup_i.source_kill_flag) begin
      dest1 = '0;
    end
    if (use_flags && lookup_i.entry_cpu_copy_flag) begin
      cpuq1[global_q[F_ADR_Q +: 3]] = 1'b1;
    end
  end

  // ----------------------------------------
  // Storm policers
  // ----------------------------------------
  logic [4:0] tick_cnt_q;
  logic tick;
  logic [NPOL-1:0] cls;
  logic [NPOL-1:0] active;
  logic [NPOL-1:0] exceeded;
  logic policed;
  logic [22:0] acc_q [NPOL];
  logic [22:0] add [NPOL];
  logic [3:0] rate_exp [NPOL];
  logic [NPOL-1:0] refill;
  logic bcast;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || tick) begin
      tick_cnt_q <= 5'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 5'h1;
    end
  end
  assign tick = tick_cnt_q == 5'(TICK_CYC - 1);

  always_comb begin
    bcast = frame_i.dmac == {48{1'b1}};
    cls[0] = frame_i.flooded && bcast;
    cls[1] = frame_i.flooded && frame_i.dmac[40] && !bcast;
    cls[2] = frame_i.flooded && !frame_i.dmac[40];
    cls[3] = to_cpu_lrn;
    for (int i = 0; i < NPOL; i++) begin
      active[i] = frame_i.valid && cls[i] && storm_cfg_q[i][F_EN];
      exceeded[i] = active[i] && tokens_q[i] == 8'h0;
      // Frames per second gained each microsecond: 2^rate times unit
      // Exponents above ten are held at ten to keep the millionths accumulator in range
      rate_exp[i] = storm_cfg_q[i][F_RATE +: 4];
      if (rate_exp[i] > MAX_RATE_EXP) begin
        rate_exp[i] = MAX_RATE_EXP;
      end
      add[i] = 23'(1) << rate_exp[i];
      if (storm_cfg_q[i][F_UNIT]) begin
        add[i] = 23'(add[i] * KILO);
      end
      refill[i] = acc_q[i] >= TICKS_PER_S;
    end
    policed = |exceeded;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NPOL; i++) begin
        acc_q[i] <= 23'h0;
        tokens_q[i] <= 8'h0;
      end
    end else begin
      for (int i = 0; i < NPOL; i++) begin
        // Fraction of a frame carried in millionths
        acc_q[i] <= acc_q[i] - (refill[i] ? TICKS_PER_S : 23'h0)
          + (tick ? add[i] : 23'h0);
        if (active[i] && !policed && tokens_q[i] != 8'h0) begin
          tokens_q[i] <= tokens_q[i] - 8'h1;
        end else if (refill[i] && tokens_q[i] < storm_burst_q[8 * i +: 8]) begin
          tokens_q[i] <= tokens_q[i] + 8'h1;
        end else if (tokens_q[i] > storm_burst_q[8 * i +: 8]) begin
          tokens_q[i] <= storm_burst_q[8 * i +: 8];
        end
      end
    end
  end

  // ----------------------------------------
  // Storm action and outputs
  // ----------------------------------------
  sls_storm_mode_t mode;
  logic [NPORT-1:0] dest2;
  logic [7:0] cpuq2;

  always_comb begin
    mode = SM_CLR_CPU_QUEUE_SET;
    for (int i = 0; i < NPOL; i++) begin
      if (exceeded[i] && storm_cfg_q[i][F_MODE +: 2] > mode) begin
        mode = sls_storm_mode_t'(storm_cfg_q[i][F_MODE +: 2]);
      end
    end
    dest2 = dest1;
    cpuq2 = cpuq1;
    if (policed) begin
      if (mode != SM_CLR_DESTINATION_PORT_SET) begin
        cpuq2 = '0;
      end
      if (mode != SM_CLR_CPU_QUEUE_SET) begin
        dest2 = '0;
      end
      if (frame_i.port_group_mask_cpu) begin
        dest2[CPU_PORT] = dest1[CPU_PORT];
        cpuq2 = cpuq1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      result_o <= '0;
      learn_o <= '0;
    end else begin
      result_o.valid <= frame_i.valid;
      result_o.destination_port_set <= dest2;
      result_o.cpu_queue_set <= cpuq2;
      result_o.learn_frame <= normal_lrn || limit_lrn || locked_lrn;
      result_o.storm_dropped <= policed;
      learn_o.valid <= normal_lrn && pcfg[F_AUTO];
      learn_o.smac <= frame_i.smac;
      learn_o.vid <= frame_i.vid;
      learn_o.port <= frame_i.logical_ingress_port;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      learn_cnt_q <= 16'h0;
      drop_cnt_q <= 16'h0;
    end else begin
      if (normal_lrn && pcfg[F_AUTO]) begin
        learn_cnt_q <= learn_cnt_q + 16'h1;
      end
      if (policed) begin
        drop_cnt_q <= drop_cnt_q + 16'h1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_kill_frame;
    frame_i.valid && lookup_i.hit && lookup_i.source_kill_flag && !global_q[F_IGNORE]
      && !frame_i.port_group_mask_cpu;
  endsequence

  a_kill_clears_destination_port_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_kill_frame |=> result_o.destination_port_set == '0)
    else $error("source kill did not clear destinations");

  a_learn_skip_dis: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_i.learning_disable_flag |=> !learn_o.valid && !result_o.learn_frame)
    else $error("learning happened with disable flag");

  a_port_off_skip: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pcfg[F_ON] |=> !learn_o.valid && !result_o.learn_frame)
    else $error("learning happened with port learning off");

  a_policed_no_learn: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_i.ingress_policed |=> !learn_o.valid)
    else $error("learning on policed frame");

  a_auto_learn: assert property (@(posedge ref_clk) disable iff (!rst_n)
    normal_lrn && pcfg[F_AUTO] |=> learn_o.valid && learn_o.smac == $past(frame_i.smac))
    else $error("auto learn insert missing");

  a_copy_adds_cpu: assert property (@(posedge ref_clk) disable iff (!rst_n)
    normal_lrn && pcfg[F_COPY] && !policed && !(use_flags && lookup_i.source_kill_flag)
      |=> result_o.destination_port_set[CPU_PORT])
    else $error("learn copy did not add cpu port");

  a_lock_copy_cpu: assert property (@(posedge ref_clk) disable iff (!rst_n)
    locked_lrn && pcfg[F_LCK_COPY] && !policed && !(use_flags && lookup_i.source_kill_flag)
      |=> result_o.destination_port_set[CPU_PORT])
    else $error("locked move copy did not add cpu port");

  a_locked_class: assert property (@(posedge ref_clk) disable iff (!rst_n)
    locked_lrn |=> result_o.learn_frame && !learn_o.valid)
    else $error("locked move also classed as normal learn");

  a_storm_drop_destination_port_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    policed && mode == SM_CLR_DESTINATION_PORT_SET && !frame_i.port_group_mask_cpu
      |=> result_o.storm_dropped && result_o.destination_port_set == '0)
    else $error("storm policing did not clear destinations");

  a_port_group_mask_cpu_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    policed && frame_i.port_group_mask_cpu && dest1[CPU_PORT]
      |=> result_o.destination_port_set[CPU_PORT])
    else $error("cpu port lost under storm policing");

  a_burst_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    refill[1] && !active[1] && tokens_q[1] >= storm_burst_q[15:8]
      && !(reg_wr && reg_addr == A_STORM_BURST) |=> tokens_q[1] <= storm_burst_q[15:8])
    else $error("allowance above burst size");

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick |=> !tick [*8])
    else $error("tick came too soon");
endmodule : sls_smac_storm
`default_nettype wire

/* sls_table_model.sv */
// Source address table model answering lookups for the learning stage
// Assumes frames come from the bench and insert requests from the stage
`timescale 1ns/1ps
`default_nettype none
module sls_table_model
  import sls_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Lookup and insert
  input wire sls_frame_t frame_i,
  input wire sls_learn_t learn_i,
  output sls_lookup_t lookup_o,
  // Entry flags chosen by the bench: limit, locked, kill, copy
  input wire logic [3:0] flags_i
);
  logic [59:0] key_q [8];
  logic [2:0] idx_q [8];
  int n_q = 0;
  int k;
  // ----------------------------------------
  // Lookup in the frame's own cycle
  // ----------------------------------------
  always_comb begin
    lookup_o = '0;
    lookup_o.limit_exceeded = flags_i[3];
    for (int i = 0; i < n_q; i++) begin
      if (key_q[i] == {frame_i.smac, frame_i.vid}) begin
        lookup_o.hit = 1'b1;
        lookup_o.entry_destination_index = idx_q[i];
        lookup_o.locked = flags_i[2];
        lookup_o.source_kill_flag = flags_i[1];
        lookup_o.entry_cpu_copy_flag = flags_i[0];
      end
    end
  end
  // ----------------------------------------
  // Insert or move an entry
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (learn_i.valid) begin
      k = n_q;
      for (int i = 0; i < n_q; i++) begin
        if (key_q[i] == {learn_i.smac, learn_i.vid}) k = i;
      end
      if (k < 8) begin
        key_q[k] <= {learn_i.smac, learn_i.vid};
        idx_q[k] <= learn_i.port;
        if (k == n_q) n_q <= n_q + 1;
      end
    end
  end
endmodule : sls_table_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the learning and storm policing stage
// Assumes the table model answers lookups in the frame's own cycle
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top
  import sls_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  sls_frame_t frame_i = '0;
  sls_lookup_t lookup_i;
  sls_result_t result_o;
  sls_learn_t learn_o;
  logic [3:0] flags = 4'h0;
  logic [47:0] da [3] = '{48'hffffffffffff, 48'h010000000005, 48'h020000000005};
  int err_count = 0;
  int n_tests = 0;
  always #20 ref_clk = ~ref_clk;
  sls_smac_storm i_sls_smac_storm (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .frame_i, .lookup_i, .result_o, .learn_o);
  sls_table_model i_sls_table_model (.ref_clk, .frame_i, .learn_i(learn_o),
    .lookup_o(lookup_i), .flags_i(flags));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic pc(input logic [2:0] p, input logic [7:0] v);
    wr(A_PORT_CFG + 8'({p, 2'b00}), {24'h0, v});
  endtask : pc
  // Flags: learning disabled, ingress policed, flooded, group mask with CPU
  task automatic snd(input logic [2:0] p, input logic [47:0] sa, input logic [47:0] d,
    input logic [3:0] fl);
    @(posedge ref_clk);
    frame_i <= {1'b1, p, p, d, sa, 12'h00a, 5'h03, 8'h01, fl};
    @(posedge ref_clk);
    frame_i.valid <= 1'b0;
    #1;
  endtask : snd
  task automatic ck(input logic [4:0] d, input logic [7:0] q, input logic [1:0] lf,
    input logic lv);
    `CHK("result valid", 1'b1, result_o.valid)
    `CHK("destination_port_set", d, result_o.destination_port_set)
    `CHK("cpu_queue_set", q, result_o.cpu_queue_set)
    `CHK("learn, drop", lf, {result_o.learn_frame, result_o.storm_dropped})
    `CHK("insert", lv, learn_o.valid)
  endtask : ck
  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(A_PORT_CFG + 8'h08, v);
    `CHK("port cfg reset", 32'h3, v)
    rd(8'h7c, v);
    `CHK("unmapped", 32'h0, v)
    wr(A_GLOBAL, 32'h7650);
    rd(A_GLOBAL, v);
    `CHK("global", 32'h7650, v)
    $display("Test registers done");
    snd(1, 48'h1, da[2], 4'h0);
    ck(5'h03, 8'h01, 2'b10, 1'b1);
    `CHK("insert mac", 60'h00000000001_00a, {learn_o.smac, learn_o.vid})
    `CHK("insert port", 3'h1, learn_o.port)
    snd(1, 48'h1, da[2], 4'h0);
    ck(5'h03, 8'h01, 2'b00, 1'b0);
    snd(2, 48'h1, da[2], 4'h0);
    ck(5'h03, 8'h01, 2'b10, 1'b1);
    flags = 4'h4;
    pc(1, 8'h41);
    snd(1, 48'h1, da[2], 4'h0);
    ck(5'h13, 8'h41, 2'b10, 1'b0);
    pc(1, 8'h81);
    snd(1, 48'h1, da[2], 4'h0);
    ck(5'h00, 8'h01, 2'b10, 1'b0);
    flags = 4'h8;
    pc(3, 8'h21);
    snd(3, 48'h2, da[2], 4'h0);
    ck(5'h00, 8'h01, 2'b10, 1'b0);
    pc(3, 8'h11);
    snd(3, 48'h2, da[2], 4'h0);
    ck(5'h13, 8'h21, 2'b10, 1'b0);
    flags = 4'h0;
    pc(0, 8'h09);
    snd(0, 48'h4, da[2], 4'h0);
    ck(5'h00, 8'h01, 2'b10, 1'b0);
    pc(0, 8'h05);
    snd(0, 48'h4, da[2], 4'h0);
    ck(5'h13, 8'h21, 2'b10, 1'b0);
    pc(0, 8'hfe);
    snd(0, 48'h4, da[2], 4'h0);
    ck(5'h03, 8'h01, 2'b00, 1'b0);
    snd(2, 48'h6, da[2], 4'h8);
    ck(5'h03, 8'h01, 2'b00, 1'b0);
    snd(2, 48'h6, da[2], 4'h4);
    ck(5'h03, 8'h01, 2'b00, 1'b0);
    flags = 4'h3;
    snd(2, 48'h1, da[2], 4'h0);
    ck(5'h00, 8'h81, 2'b00, 1'b0);
    wr(A_GLOBAL, 32'h7651);
    snd(2, 48'h1, da[2], 4'h0);
    ck(5'h03, 8'h01, 2'b00, 1'b0);
    wr(A_GLOBAL, 32'h7650);
    flags = 4'h0;
    rd(A_LEARN_CNT, v);
    `CHK("learn count", 32'h2, v)
    $display("Test learning done");
    for (int p = 0; p < 3; p++) begin
      wr(A_STORM_CFG + 8'(4 * p), 32'h80 | 32'(p << 5));
      for (int c = 0; c < 3; c++) begin
        snd(2, 48'h1, da[c], 4'ha);
        ck((c == p && p != 0) ? 5'h00 : 5'h03, (c == p && p != 1) ? 8'h00 : 8'h01,
          {1'b0, c == p}, 1'b0);
      end
      wr(A_STORM_CFG + 8'(4 * p), 32'h0);
    end
    wr(A_STORM_CFG, 32'hc0);
    snd(2, 48'h1, da[0], 4'h8);
    ck(5'h03, 8'h01, 2'b00, 1'b0);
    snd(2, 48'h1, da[0], 4'hb);
    ck(5'h00, 8'h01, 2'b01, 1'b0);
    wr(A_STORM_CFG, 32'h0);
    wr(A_STORM_CFG + 8'h0c, 32'he0);
    pc(0, 8'h05);
    snd(0, 48'h4, da[2], 4'h0);
    ck(5'h00, 8'h00, 2'b11, 1'b0);
    snd(0, 48'h4, da[2], 4'h1);
    ck(5'h10, 8'h21, 2'b11, 1'b0);
    wr(A_STORM_CFG + 8'h0c, 32'h0);
    $display("Test slow policers done");
    wr(A_STORM_BURST, 32'h10100210);
    wr(A_STORM_CFG + 8'h04, 32'h9a);
    repeat (200) @(posedge ref_clk);
    rd(A_TOKENS, v);
    `CHK("tokens", 8'h02, v[15:8])
    snd(2, 48'h1, da[1], 4'ha);
    ck(5'h03, 8'h01, 2'b00, 1'b0);
    rd(A_DROP_CNT, v);
    `CHK("drop count", 32'h6, v)
    $display("Test token refill done");
    tally_and_finish();
  end
  initial begin
    #(40 * 4000);
    err_count++;
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
